// [logic/bzd_buzzer.v]
// buzzer output driver sharing two port pins
`include "bzd_map.vh"
module bzd_buzzer #(
  parameter MODE = `BZD_MODE_PAIR,  // pin mode option
  parameter SRC  = `BZD_SRC_XTAL,   // source clock option
  parameter EXP  = `BZD_EXP_MIN     // ratio exponent, 2..9
) (
  input  wire clk,
  input  wire reset_n,
  input  wire xtal_32k,
  input  wire internal_low_speed_rc,
  input  wire direction_bit_first,
  input  wire direction_bit_second,
  input  wire port_data_first,
  input  wire port_data_second,
  input  wire shared_pin_first_in,
  input  wire shared_pin_second_in,
  output reg  shared_pin_first_out,
  output reg  shared_pin_first_oe,
  output reg  shared_pin_second_out,
  output reg  shared_pin_second_oe,
  output reg  pin_first_read,
  output reg  pin_second_read,
  output reg  buzzer_out_true
);
  // sync stages for the two slow oscillators and pin inputs
  reg  [2:0] xs;   // 32768Hz oscillator
  reg  [2:0] rs;   // internal rc oscillator
  reg  [2:0] p0s;  // first pin level
  reg  [2:0] p1s;  // second pin level
  reg  [1:0] sdiv; // system clock prescaler
  reg        src_tick; // one pulse per rising source edge
  reg        xl;       // settled 32768Hz level, moves only when stages agree
  reg        rl;       // settled rc level, moves only when stages agree
  wire       wave;     // divider output
  reg        next_out0, next_oe0, next_out1, next_oe1;

  // three-stage synchronisers, change counted when stages 2 and 3 agree
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xs  <= 3'h0;
      rs  <= 3'h0;
      p0s <= 3'h0;
      p1s <= 3'h0;
    end else begin
      xs  <= {xs[1:0], xtal_32k};
      rs  <= {rs[1:0], internal_low_speed_rc};
      p0s <= {p0s[1:0], shared_pin_first_in};
      p1s <= {p1s[1:0], shared_pin_second_in};
    end
  end

  // select the source; rising edges become ticks
  // source is fixed by parameter, nothing at run time reaches it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdiv     <= 2'h0;
      src_tick <= 1'b0;
      xl       <= 1'b0;
      rl       <= 1'b0;
    end else begin
      sdiv <= sdiv + 2'h1;
      // a level only counts once stages 2 and 3 agree, so a glitch cannot tick
      if (xs[1] == xs[2])
        xl <= xs[2];
      if (rs[1] == rs[2])
        rl <= rs[2];
      case (SRC)
        `BZD_SRC_XTAL: src_tick <= (xs[1] == xs[2]) & xs[2] & ~xl; // RULE4 RULE5
        `BZD_SRC_RC:   src_tick <= (rs[1] == rs[2]) & rs[2] & ~rl; // RULE4
        default:       src_tick <= (sdiv == `BZD_SYS_DIV); // RULE4
      endcase
    end
  end

  // square wave at source / 2^EXP
  bzd_divider #(
    .EXP (EXP)
  ) u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (src_tick),
    .wave    (wave)
  );

  // pin function decode by mode, direction and data
  always @* begin
    next_out0 = port_data_first;
    next_oe0  = ~direction_bit_first;   // RULE9 RULE10
    next_out1 = port_data_second;
    next_oe1  = ~direction_bit_second;  // RULE10
    case (MODE)
      `BZD_MODE_PAIR: begin
        // first data bit gates both; second data bit drives the second pin only while the first pin is an input
        next_out0 = port_data_first & wave;  // RULE6 RULE1
        if (!direction_bit_first)
          next_out1 = port_data_first & ~wave; // RULE2 RULE6 RULE7
        else
          next_out1 = port_data_second;        // RULE11
      end
      `BZD_MODE_SINGLE: begin
        next_out0 = port_data_first & wave;  // RULE8 RULE1
      end
      default: begin
        next_out0 = port_data_first;         // RULE1
      end
    endcase
  end

  // registered pin drive and synchronised read-back
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shared_pin_first_out  <= 1'b0;
      shared_pin_first_oe   <= 1'b0;
      shared_pin_second_out <= 1'b0;
      shared_pin_second_oe  <= 1'b0;
      pin_first_read        <= 1'b0;
      pin_second_read       <= 1'b0;
      buzzer_out_true       <= 1'b0;
    end else begin
      shared_pin_first_out  <= next_out0;
      shared_pin_first_oe   <= next_oe0;
      shared_pin_second_out <= next_out1;
      shared_pin_second_oe  <= next_oe1;
      buzzer_out_true       <= wave;
      if (p0s[1] == p0s[2])
        pin_first_read <= p0s[2];
      if (p1s[1] == p1s[2])
        pin_second_read <= p1s[2];
    end
  end
endmodule // bzd_buzzer

// [logic/bzd_map.vh]
// constants for the buzzer output driver
// Function
// (RULE1) option picks off, pair or single pin mode
// (RULE2) pair mode second output inverts first output
// (RULE3) frequency is source over two power 2..9
// (RULE4) source is 32768Hz, internal RC, system/4
// (RULE5) frequency fixed by options, no register
// (RULE6) pair outputs gated by first data bit
// (RULE7) second data bit never gates inverted output
// (RULE8) single mode first pin gated, second plain port
// (RULE9) first direction bit high makes pin input
// (RULE10) input direction overrides buzzer at any time
// (RULE11) pair mode, first input: second drives data
// (RULE12) output is toggled square wave, equal halves
`ifndef BZD_MAP_VH
`define BZD_MAP_VH
// pin mode option codes
`define BZD_MODE_PORT   2'h0
`define BZD_MODE_PAIR   2'h1
`define BZD_MODE_SINGLE 2'h2
// source option codes
`define BZD_SRC_XTAL    2'h0
`define BZD_SRC_RC      2'h1
`define BZD_SRC_SYSDIV  2'h2
// divider exponent limits and system prescale
`define BZD_EXP_MIN     4'h2
`define BZD_EXP_MAX     4'h9
`define BZD_SYS_DIV     2'h3
// reset values of the port registers: inputs, data low
`define BZD_DIR_RESET   1'h1
`define BZD_DATA_RESET  1'h0
`endif

// [logic/bzd_divider.v]
// power-of-two divider with toggling square-wave output
module bzd_divider #(
  parameter EXP = 4'h2
) (
  input  wire clk,
  input  wire reset_n,
  input  wire tick,
  output reg  wave
);
  // half period is 2^(EXP-1) source ticks, so full period is 2^EXP
  reg [8:0] count; // source tick counter
  wire      last = (count == ((9'h001 << (EXP - 1)) - 9'h001));

  // count source ticks and toggle at the divider output
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 9'h000;
      wave  <= 1'b0;
    end else if (tick) begin
      if (last) begin
        count <= 9'h000;
        wave  <= ~wave; // RULE12 RULE3
      end else begin
        count <= count + 9'h001;
      end
    end
  end
endmodule // bzd_divider

// [sim/bzd_chk_sva.sv]
// pin checker for the buzzer driver
module bzd_chk #(parameter MODE = 1, parameter SRC = 2, parameter EXP = 2) (
  input wire clk, reset_n, direction_bit_first, direction_bit_second,
  input wire port_data_first, port_data_second, buzzer_out_true,
  input wire shared_pin_first_out, shared_pin_first_oe,
  input wire shared_pin_second_out, shared_pin_second_oe);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // both pins set to output, the pair case
  wire on2 = !direction_bit_first && !direction_bit_second;
  // half period of 8 clk holds only for source clk/4 with ratio exponent 2
  wire fast = SRC == 2 && EXP == 2;
  chk_pair_inverse: assert property (MODE == 1 && $past(reset_n && on2 && port_data_first) |->
    shared_pin_second_out == !shared_pin_first_out) else $error("pair not inverse");
  chk_pair_gate: assert property (MODE == 1 && $past(reset_n && on2 && !port_data_first) |->
    !shared_pin_first_out && !shared_pin_second_out) else $error("gated pair not low");
  chk_pair_drive: assert property (MODE == 1 && $past(reset_n && on2) |->
    shared_pin_first_oe && shared_pin_second_oe) else $error("pair not driven");
  chk_first_input: assert property ($past(direction_bit_first) |->
    !shared_pin_first_oe) else $error("first pin driven as input");
  chk_second_input: assert property ($past(direction_bit_second) |->
    !shared_pin_second_oe) else $error("second pin driven as input");
  chk_second_data: assert property (MODE == 1 && $past(reset_n && direction_bit_first &&
    !direction_bit_second) |-> shared_pin_second_oe &&
    shared_pin_second_out == $past(port_data_second)) else $error("second data wrong");
  chk_wave_high: assert property (fast && $rose(buzzer_out_true) |->
    buzzer_out_true[*8] ##1 !buzzer_out_true) else $error("high half wrong");
  chk_wave_low: assert property (fast && $fell(buzzer_out_true) |->
    !buzzer_out_true[*8] ##1 buzzer_out_true) else $error("low half wrong");
  cover property ($rose(buzzer_out_true));
  cover property (on2 && port_data_first);
  cover property (direction_bit_first && !direction_bit_second);
endmodule // bzd_chk
bind bzd_buzzer bzd_chk #(.MODE(MODE), .SRC(SRC), .EXP(EXP)) bzd_chk_inst (.*);

// [sim/bzd_piezo.sv]
// far-side load model: resolves both shared pins
module bzd_piezo (input wire ao, ae, bo, be, output wire ap, bp);
  timeunit 1ns; timeprecision 1ns;
  logic al = 0, bl = 0; // last level driven on each pin
  always @* if (ae) al = ao;
  always @* if (be) bl = bo;
  // a released pin floats, so show the inverse of its last level
  assign ap = ae ? ao : !al;
  assign bp = be ? bo : !bl;
endmodule // bzd_piezo

// [sim/test_bzd_buzzer.sv]
// bench for the buzzer driver in pair mode
module test_bzd_buzzer;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, reset_n = 0, d1 = 1, d2 = 1, p1 = 0, p2 = 0, lw;
  wire ao, ae, bo, be, ap, bp, r1, r2, wv;
  int bad_count = 0, compares = 0, rises;
  always #25 clk = !clk;
  bzd_buzzer #(.MODE(1), .SRC(2), .EXP(2)) bzd_buzzer_inst (.clk(clk), .reset_n(reset_n),
    .xtal_32k(1'b0), .internal_low_speed_rc(1'b0), .direction_bit_first(d1),
    .direction_bit_second(d2), .port_data_first(p1), .port_data_second(p2),
    .shared_pin_first_in(ap), .shared_pin_second_in(bp), .shared_pin_first_out(ao),
    .shared_pin_first_oe(ae), .shared_pin_second_out(bo), .shared_pin_second_oe(be),
    .pin_first_read(r1), .pin_second_read(r2), .buzzer_out_true(wv));
  bzd_piezo bzd_piezo_inst (.ao(ao), .ae(ae), .bo(bo), .be(be), .ap(ap), .bp(bp));
  task automatic check_bit(string what, logic e, logic g);
    compares++;
    if (g !== e) begin bad_count++; $display("CHECK FAILED %s expected %b seen %b", what, e, g); end
  endtask
  task automatic check_count(string what, int e, int g);
    compares++;
    if (g != e) begin bad_count++; $display("CHECK FAILED %s expected %0d seen %0d", what, e, g); end
  endtask
  // second pin level when it is an output: own data, inverse wave, or gated low
  function automatic logic want_second(logic f, logic a, logic b, logic w);
    return f ? b : (a ? !w : 1'b0);
  endfunction
  task automatic close_out;
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(81));
    repeat (16) @(posedge clk);
    #2 reset_n = 1;
    {d1, d2, p1, p2} = 4'h2; // pair running
    repeat (4) @(posedge clk);
    rises = 0;
    lw = wv;
    // sys/4 source and ratio 4 give a 16 clk period
    repeat (64) begin @(posedge clk); #2 rises += (wv && !lw); lw = wv; end
    check_count("wave rises", 64 / (4 * (1 << 2)), rises);
    // mid-run reset: first pin must let go at once and the wave must clear
    reset_n = 0;
    @(posedge clk);
    #2 check_bit("reset first_oe", 1'b0, ae);
    check_bit("reset wave", 1'b0, wv);
    reset_n = 1;
    repeat (40) begin
      @(posedge clk);
      #2 {d1, d2, p1, p2} = 4'($urandom);
      repeat (8) @(posedge clk);
      #2 check_bit("first_oe", !d1, ae);
      check_bit("second_oe", !d2, be);
      if (!d2) check_bit("second_out", want_second(d1, p1, p2, wv), bo);
      if (!d1) check_bit("first_out", p1 && wv, ao);
      if (d1) check_bit("first_read", ap, r1);
      if (d2) check_bit("second_read", bp, r2);
    end
    close_out;
  end
  initial begin #100000; bad_count++; close_out; end
endmodule // test_bzd_buzzer
